/* File: design/ntsa_consts.svh */
/*
 * Constants for the contactless state and access unit: command codes, register offsets,
 * field positions and reset values.
 * Assumes it is included by bare name from the unit, the reader model and the testbench.
 */
`ifndef NTSA_CONSTS_SVH
`define NTSA_CONSTS_SVH
// contactless command codes, first frame byte
`define NTSA_CMD_REQ 8'h26
`define NTSA_CMD_WAKE 8'h52
`define NTSA_CMD_CL1 8'h93
`define NTSA_CMD_CL2 8'h95
`define NTSA_ARG_ANTICOLL 8'h20
`define NTSA_ARG_SELECT 8'h70
`define NTSA_CMD_HALT 8'h50
`define NTSA_ARG_HALT 8'h00
`define NTSA_CMD_READ 8'h30
`define NTSA_CMD_WRITE 8'ha2
`define NTSA_CMD_TAG_KEY 8'h1b
`define NTSA_CMD_DM_FETCH 8'h51
`define NTSA_CMD_DM_STORE 8'h54
`define NTSA_CMD_GET_RD_LOCK 8'h6a
`define NTSA_CMD_GET_WR_LOCK 8'h6c
`define NTSA_CMD_SET_RD_LOCK 8'h7f
`define NTSA_CMD_SET_WR_LOCK 8'h7e
`define NTSA_CMD_DM_KEY 8'h40
// payload sizes in bytes
`define NTSA_DM_BLOCK_BYTES 7'h40
`define NTSA_NO_PAYLOAD 7'h00
// register byte offsets
`define NTSA_OFS_STATUS 12'h000
`define NTSA_OFS_MIRROR 12'h004
`define NTSA_OFS_GUARD 12'h008
`define NTSA_OFS_KEY 12'h00c
`define NTSA_OFS_KEY_ACK 12'h010
`define NTSA_OFS_DM_KEY 12'h014
`define NTSA_OFS_UID_LO 12'h018
`define NTSA_OFS_UID_HI 12'h01c
`define NTSA_OFS_RDLK_LO 12'h020
`define NTSA_OFS_RDLK_HI 12'h024
`define NTSA_OFS_WRLK_LO 12'h028
`define NTSA_OFS_WRLK_HI 12'h02c
// field positions inside the mirror and guard registers
`define NTSA_MIR_CONF_LSB 0
`define NTSA_MIR_BYTE_LSB 4
`define NTSA_MIR_BLOCK_LSB 8
`define NTSA_LIMIT_LSB 8
// reset values and mirror constants
`define NTSA_GUARD_OFF 8'hff
`define NTSA_MIR_CONF_ON 2'b01
`define NTSA_MIR_BLOCK_MIN 8'h03
`define NTSA_MIR_LEN 10'h00e
`define NTSA_ASCII_DIGIT 8'h30
`define NTSA_ASCII_LETTER 8'h37
`define NTSA_NIB_TEN 4'ha
`endif

/* File: design/ntsa_pkg.sv */
/*
 * Types of the contactless state and access unit: state codes, answer kinds, state record.
 * Assumes the constants header is on the include path.
 */
`default_nettype none
package ntsa_pkg;
	// one-hot card states
	typedef enum logic [7:0] {
		NTSA_IDLE = 8'h01,
		NTSA_LVL1 = 8'h02,
		NTSA_LVL2 = 8'h04,
		NTSA_TAG_ACT = 8'h08,
		NTSA_DM_ACT = 8'h10,
		NTSA_TAG_AUTH = 8'h20,
		NTSA_DM_AUTH = 8'h40,
		NTSA_HALT = 8'h80
	} ntsa_state_t;

	// kind of answer handed to the framer
	typedef enum logic [3:0] {
		NTSA_RSP_NONE = 4'h0,
		NTSA_RSP_ATQ = 4'h1,
		NTSA_RSP_UID1 = 4'h2,
		NTSA_RSP_SAK_MORE = 4'h3,
		NTSA_RSP_UID2 = 4'h4,
		NTSA_RSP_SAK_DONE = 4'h5,
		NTSA_RSP_ACK = 4'h6,
		NTSA_RSP_NAK = 4'h7,
		NTSA_RSP_DATA = 4'h8,
		NTSA_RSP_KEY_ACK = 4'h9,
		NTSA_RSP_LOCKMAP = 4'ha,
		NTSA_RSP_DM_DATA = 4'hb
	} ntsa_rsp_t;

	// whole state of the unit
	typedef struct packed {
		ntsa_state_t st;
		logic halted;
		logic [2:0] fails;
		logic [63:0] rd_lock;
		logic [63:0] wr_lock;
		logic [1:0] mir_conf;
		logic [1:0] mir_byte;
		logic [7:0] mir_block;
		logic [7:0] guard;
		logic [2:0] limit;
		logic [31:0] key;
		logic [15:0] key_ack;
		logic [31:0] dm_key;
		logic [55:0] uid;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic rsp_valid;
		ntsa_rsp_t rsp_kind;
		logic [127:0] rsp_data;
		logic dm_rd_go;
		logic dm_wr_go;
		logic [5:0] dm_region;
		logic tag_wr_go;
		logic [7:0] tag_wr_block;
		logic [31:0] tag_wr_data;
	} ntsa_regs_t;
endpackage
`default_nettype wire

/* File: design/ntsa_unit.sv */
/*
 * Contactless card state machine with data-memory lock bitmaps, uid ascii mirror and
 * tag key guard, configured over an APB slave.
 * Assumes a framer on pclk that delivers decoded, checked frames and sends the answers,
 * and tag memory that returns 16 bytes at frame_arg combinationally.
 */
// Behaviour
// - level-one state resolves 3 uid bytes; level-one select moves to level two.
// - READ of block 0 in either cascade state jumps straight to tag active.
// - unexpected frame in level one returns to the current wait state.
// - level-two state answers anticollision with 4 uid bytes; select ends it.
// - level-two select answers with cascade-complete SAK; device is then selected.
// - unexpected frame in level two returns to the current wait state.
// - tag active: halt request goes to halt, other errors to wait state.
// - good tag key in tag active enters tag authenticated.
// - good data key enters data authenticated; errors in data active go idle.
// - tag authenticated opens guarded blocks; halt to halt; errors to wait state.
// - data authenticated opens lock updates; unexpected frames go idle.
// - halt is left only by wake-up; other frames leave it unchanged.
// - data block fetch and store move exactly 64 bytes.
// - a set lock bit makes the matching 64-byte fetch or store answer NAK.
// - lock bitmap reads work in data active and data authenticated.
// - lock bitmap updates only run in data authenticated.
// - lock updates OR into the bitmap; bits never return to zero.
// - frames failing crc, parity or bit count are treated as errors.
// - with mirror on, READ answers show the uid as 14 ascii bytes.
// - mirror starts at block and byte; needs block above 03h and config 01b.
// - guard FFh leaves keys writable; otherwise blocks from guard need the key.
// - idle is left only on request or wake-up; other frames stay idle.
// - a halt request from tag active or tag authenticated makes halt the wait state.
`default_nettype none
`include "ntsa_consts.svh"
module ntsa_unit #(
	parameter logic [7:0] SAK_MORE = 8'h04, // sak values arbitrary, set by integration
	parameter logic [7:0] SAK_DONE = 8'h00,
	parameter logic [15:0] ATQ_VALUE = 16'h0044
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frame_valid,
	input wire logic frame_short,
	input wire logic frame_intact,
	input wire logic [7:0] frame_cmd,
	input wire logic [7:0] frame_arg,
	input wire logic [6:0] frame_nbytes,
	input wire logic [63:0] frame_data,
	input wire logic [127:0] tag_rdata,
	output logic rsp_valid,
	output ntsa_pkg::ntsa_rsp_t rsp_kind,
	output logic [127:0] rsp_data,
	output logic dm_rd_go,
	output logic dm_wr_go,
	output logic [5:0] dm_region,
	output logic tag_wr_go,
	output logic [7:0] tag_wr_block,
	output logic [31:0] tag_wr_data,
	output ntsa_pkg::ntsa_state_t rf_state
);
	import ntsa_pkg::*;

	ntsa_regs_t s_r;
	ntsa_regs_t s_nxt;

	// two-byte command match, used for every anticollision and halt frame
	function automatic logic cmd2(input logic [7:0] c, input logic [7:0] a, input logic [7:0] ec,
		input logic [7:0] ea);
		cmd2 = (c == ec) && (a == ea);
	endfunction

	// one nibble to its ascii hex digit
	function automatic logic [7:0] hex_ascii(input logic [3:0] n);
		hex_ascii = (n < `NTSA_NIB_TEN) ? (`NTSA_ASCII_DIGIT + {4'h0, n}) : (`NTSA_ASCII_LETTER + {4'h0, n});
	endfunction

	// mirror window per answer byte; overlap is checked byte by byte so any start byte works
	logic mir_on;
	logic [9:0] mir_start;
	logic [127:0] read_view;
	assign mir_on = (s_r.mir_conf == `NTSA_MIR_CONF_ON) && (s_r.mir_block > `NTSA_MIR_BLOCK_MIN);
	assign mir_start = {s_r.mir_block, s_r.mir_byte};
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_mir
			logic [9:0] abs_idx;
			logic [9:0] off;
			logic [7:0] ubyte;
			assign abs_idx = {frame_arg, 2'b00} + 10'(gi);
			assign off = abs_idx - mir_start;
			assign ubyte = s_r.uid[{off[3:1], 3'b000} +: 8];
			// high nibble first, so each uid byte becomes two characters
			assign read_view[gi*8 +: 8] = (mir_on && abs_idx >= mir_start && off < `NTSA_MIR_LEN) ?
				hex_ascii(off[0] ? ubyte[3:0] : ubyte[7:4]) : tag_rdata[gi*8 +: 8];
		end
	endgenerate

	// frame classification
	logic is_req;
	logic is_wake;
	logic is_halt;
	logic is_read;
	logic is_read0;
	logic guarded;
	logic key_ok;
	logic dm_ok;
	logic dm_cmd;
	ntsa_state_t wait_st;
	assign is_req = frame_short && frame_cmd == `NTSA_CMD_REQ;
	assign is_wake = frame_short && frame_cmd == `NTSA_CMD_WAKE;
	assign is_halt = !frame_short && cmd2(frame_cmd, frame_arg, `NTSA_CMD_HALT, `NTSA_ARG_HALT);
	assign is_read = !frame_short && frame_cmd == `NTSA_CMD_READ && frame_nbytes == `NTSA_NO_PAYLOAD;
	assign is_read0 = is_read && frame_arg == 8'h00;
	assign guarded = (s_r.guard != `NTSA_GUARD_OFF) && (frame_arg >= s_r.guard);
	// once the limit is reached every tag key verification fails, right key or not; the data key has no limit
	assign key_ok = (frame_data[31:0] == s_r.key) && !(s_r.limit != 3'h0 && s_r.fails >= s_r.limit);
	assign dm_ok = frame_data[31:0] == s_r.dm_key;
	assign dm_cmd = !frame_short && (frame_cmd == `NTSA_CMD_DM_FETCH || frame_cmd == `NTSA_CMD_DM_STORE ||
		frame_cmd == `NTSA_CMD_GET_RD_LOCK || frame_cmd == `NTSA_CMD_GET_WR_LOCK ||
		frame_cmd == `NTSA_CMD_SET_RD_LOCK || frame_cmd == `NTSA_CMD_SET_WR_LOCK ||
		frame_cmd == `NTSA_CMD_DM_KEY);
	assign wait_st = s_r.halted ? NTSA_HALT : NTSA_IDLE;

	// apb decode
	logic apb_setup;
	logic apb_wr;
	logic key_open;
	assign apb_setup = psel && !penable && !s_r.pready;
	assign apb_wr = psel && penable && s_r.pready && pwrite;
	assign key_open = (s_r.guard == `NTSA_GUARD_OFF) || (s_r.st == NTSA_TAG_AUTH);

	// next state: apb access first, then one frame per cycle
	always_comb begin
		s_nxt = s_r;
		s_nxt.pready = apb_setup;
		s_nxt.rsp_valid = 1'b0;
		s_nxt.rsp_kind = NTSA_RSP_NONE;
		s_nxt.dm_rd_go = 1'b0;
		s_nxt.dm_wr_go = 1'b0;
		s_nxt.tag_wr_go = 1'b0;
		// read data is latched in setup so it comes from a flop in the access cycle
		if (apb_setup) begin
			s_nxt.pslverr = 1'b0;
			unique case (paddr)
				`NTSA_OFS_STATUS: s_nxt.prdata = {20'h0, s_r.fails, s_r.halted, s_r.st};
				`NTSA_OFS_MIRROR: s_nxt.prdata = {16'h0, s_r.mir_block, 2'b00, s_r.mir_byte, 2'b00, s_r.mir_conf};
				`NTSA_OFS_GUARD: s_nxt.prdata = {21'h0, s_r.limit, s_r.guard};
				`NTSA_OFS_KEY, `NTSA_OFS_KEY_ACK, `NTSA_OFS_DM_KEY: s_nxt.prdata = 32'h0;
				`NTSA_OFS_UID_LO: s_nxt.prdata = s_r.uid[31:0];
				`NTSA_OFS_UID_HI: s_nxt.prdata = {8'h0, s_r.uid[55:32]};
				`NTSA_OFS_RDLK_LO: s_nxt.prdata = s_r.rd_lock[31:0];
				`NTSA_OFS_RDLK_HI: s_nxt.prdata = s_r.rd_lock[63:32];
				`NTSA_OFS_WRLK_LO: s_nxt.prdata = s_r.wr_lock[31:0];
				`NTSA_OFS_WRLK_HI: s_nxt.prdata = s_r.wr_lock[63:32];
				default: begin
					s_nxt.prdata = 32'h0;
					s_nxt.pslverr = 1'b1;
				end
			endcase
		end
		// writes honour byte strobes only through whole-register loads of full words
		if (apb_wr && pstrb == 4'hf) begin
			unique case (paddr)
				`NTSA_OFS_MIRROR: begin
					s_nxt.mir_conf = pwdata[`NTSA_MIR_CONF_LSB +: 2];
					s_nxt.mir_byte = pwdata[`NTSA_MIR_BYTE_LSB +: 2];
					s_nxt.mir_block = pwdata[`NTSA_MIR_BLOCK_LSB +: 8];
				end
				`NTSA_OFS_GUARD: begin
					s_nxt.guard = pwdata[7:0];
					s_nxt.limit = pwdata[`NTSA_LIMIT_LSB +: 3];
				end
				`NTSA_OFS_KEY: if (key_open) s_nxt.key = pwdata;
				`NTSA_OFS_KEY_ACK: if (key_open) s_nxt.key_ack = pwdata[15:0];
				`NTSA_OFS_DM_KEY: s_nxt.dm_key = pwdata;
				`NTSA_OFS_UID_LO: s_nxt.uid[31:0] = pwdata;
				`NTSA_OFS_UID_HI: s_nxt.uid[55:32] = pwdata[23:0];
				default: ;
			endcase
		end
		if (frame_valid) begin
			s_nxt.rsp_valid = 1'b1;
			s_nxt.rsp_data = 128'h0;
			if (!frame_intact) begin
				// a damaged frame is silent; data states drop to idle, tag states to wait state
				s_nxt.rsp_valid = 1'b0;
				unique case (s_r.st)
					NTSA_IDLE, NTSA_HALT: ;
					NTSA_DM_ACT, NTSA_DM_AUTH: s_nxt.st = NTSA_IDLE;
					default: s_nxt.st = wait_st;
				endcase
			end else begin
				unique case (s_r.st)
					NTSA_IDLE: begin
						if (is_req || is_wake) begin
							s_nxt.st = NTSA_LVL1;
							s_nxt.rsp_kind = NTSA_RSP_ATQ;
							s_nxt.rsp_data = {112'h0, ATQ_VALUE};
						end else
							s_nxt.rsp_valid = 1'b0;
					end
					NTSA_HALT: begin
						if (is_wake) begin
							s_nxt.st = NTSA_LVL1;
							s_nxt.rsp_kind = NTSA_RSP_ATQ;
							s_nxt.rsp_data = {112'h0, ATQ_VALUE};
						end else
							s_nxt.rsp_valid = 1'b0;
					end
					NTSA_LVL1, NTSA_LVL2: begin
						if (is_read0) begin
							s_nxt.st = NTSA_TAG_ACT;
							s_nxt.rsp_kind = NTSA_RSP_DATA;
							s_nxt.rsp_data = read_view;
						end else if (s_r.st == NTSA_LVL1 &&
							cmd2(frame_cmd, frame_arg, `NTSA_CMD_CL1, `NTSA_ARG_ANTICOLL)) begin
							s_nxt.rsp_kind = NTSA_RSP_UID1;
							s_nxt.rsp_data = {104'h0, s_r.uid[23:0]};
						end else if (s_r.st == NTSA_LVL1 && frame_data[23:0] == s_r.uid[23:0] &&
							cmd2(frame_cmd, frame_arg, `NTSA_CMD_CL1, `NTSA_ARG_SELECT)) begin
							s_nxt.st = NTSA_LVL2;
							s_nxt.rsp_kind = NTSA_RSP_SAK_MORE;
							s_nxt.rsp_data = {120'h0, SAK_MORE};
						end else if (s_r.st == NTSA_LVL2 &&
							cmd2(frame_cmd, frame_arg, `NTSA_CMD_CL2, `NTSA_ARG_ANTICOLL)) begin
							s_nxt.rsp_kind = NTSA_RSP_UID2;
							s_nxt.rsp_data = {96'h0, s_r.uid[55:24]};
						end else if (s_r.st == NTSA_LVL2 && frame_data[31:0] == s_r.uid[55:24] &&
							cmd2(frame_cmd, frame_arg, `NTSA_CMD_CL2, `NTSA_ARG_SELECT)) begin
							s_nxt.st = NTSA_TAG_ACT;
							s_nxt.rsp_kind = NTSA_RSP_SAK_DONE;
							s_nxt.rsp_data = {120'h0, SAK_DONE};
						end else begin
							s_nxt.st = wait_st;
							s_nxt.rsp_valid = 1'b0;
						end
					end
					NTSA_TAG_ACT, NTSA_TAG_AUTH: begin
						if (is_halt) begin
							s_nxt.st = NTSA_HALT;
							s_nxt.halted = 1'b1;
							s_nxt.rsp_valid = 1'b0;
						end else if (is_read) begin
							s_nxt.rsp_kind = (guarded && s_r.st == NTSA_TAG_ACT) ? NTSA_RSP_NAK : NTSA_RSP_DATA;
							s_nxt.rsp_data = (guarded && s_r.st == NTSA_TAG_ACT) ? 128'h0 : read_view;
						end else if (!frame_short && frame_cmd == `NTSA_CMD_WRITE && frame_nbytes == 7'h04) begin
							if (guarded && s_r.st == NTSA_TAG_ACT)
								s_nxt.rsp_kind = NTSA_RSP_NAK;
							else begin
								s_nxt.rsp_kind = NTSA_RSP_ACK;
								s_nxt.tag_wr_go = 1'b1;
								s_nxt.tag_wr_block = frame_arg;
								s_nxt.tag_wr_data = frame_data[31:0];
							end
						end else if (!frame_short && frame_cmd == `NTSA_CMD_TAG_KEY) begin
							if (key_ok) begin
								s_nxt.st = NTSA_TAG_AUTH;
								s_nxt.fails = 3'h0;
								s_nxt.rsp_kind = NTSA_RSP_KEY_ACK;
								s_nxt.rsp_data = {112'h0, s_r.key_ack};
							end else begin
								s_nxt.rsp_kind = NTSA_RSP_NAK;
								if (s_r.fails != 3'h7)
									s_nxt.fails = s_r.fails + 3'h1;
							end
						end else if (dm_cmd && s_r.st == NTSA_TAG_ACT) begin
							// data memory work starts from the selected tag; the frame is dropped unanswered
							s_nxt.st = NTSA_DM_ACT;
							s_nxt.rsp_valid = 1'b0;
						end else begin
							s_nxt.st = wait_st;
							s_nxt.rsp_valid = 1'b0;
						end
					end
					NTSA_DM_ACT, NTSA_DM_AUTH: begin
						if (!frame_short && frame_cmd == `NTSA_CMD_DM_FETCH && frame_nbytes == `NTSA_NO_PAYLOAD) begin
							s_nxt.dm_region = frame_arg[5:0];
							s_nxt.rsp_kind = s_r.rd_lock[frame_arg[5:0]] ? NTSA_RSP_NAK : NTSA_RSP_DM_DATA;
							s_nxt.dm_rd_go = !s_r.rd_lock[frame_arg[5:0]];
						end else if (!frame_short && frame_cmd == `NTSA_CMD_DM_STORE &&
							frame_nbytes == `NTSA_DM_BLOCK_BYTES) begin
							s_nxt.dm_region = frame_arg[5:0];
							s_nxt.rsp_kind = s_r.wr_lock[frame_arg[5:0]] ? NTSA_RSP_NAK : NTSA_RSP_ACK;
							s_nxt.dm_wr_go = !s_r.wr_lock[frame_arg[5:0]];
						end else if (!frame_short && frame_cmd == `NTSA_CMD_GET_RD_LOCK) begin
							s_nxt.rsp_kind = NTSA_RSP_LOCKMAP;
							s_nxt.rsp_data = {64'h0, s_r.rd_lock};
						end else if (!frame_short && frame_cmd == `NTSA_CMD_GET_WR_LOCK) begin
							s_nxt.rsp_kind = NTSA_RSP_LOCKMAP;
							s_nxt.rsp_data = {64'h0, s_r.wr_lock};
						end else if (!frame_short && frame_cmd == `NTSA_CMD_DM_KEY) begin
							if (dm_ok) begin
								s_nxt.st = NTSA_DM_AUTH;
								s_nxt.rsp_kind = NTSA_RSP_ACK;
							end else
								s_nxt.rsp_kind = NTSA_RSP_NAK;
						end else if (s_r.st == NTSA_DM_AUTH && !frame_short && frame_cmd == `NTSA_CMD_SET_RD_LOCK) begin
							s_nxt.rd_lock = s_r.rd_lock | frame_data;
							s_nxt.rsp_kind = NTSA_RSP_ACK;
						end else if (s_r.st == NTSA_DM_AUTH && !frame_short && frame_cmd == `NTSA_CMD_SET_WR_LOCK) begin
							s_nxt.wr_lock = s_r.wr_lock | frame_data;
							s_nxt.rsp_kind = NTSA_RSP_ACK;
						end else begin
							s_nxt.st = NTSA_IDLE;
							s_nxt.rsp_valid = 1'b0;
						end
					end
					default: s_nxt.st = NTSA_IDLE;
				endcase
			end
		end
	end

	// single register for all state; lock maps come up clear, guard off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.st <= NTSA_IDLE;
			s_r.guard <= `NTSA_GUARD_OFF;
		end else
			s_r <= s_nxt;
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign rsp_valid = s_r.rsp_valid;
	assign rsp_kind = s_r.rsp_kind;
	assign rsp_data = s_r.rsp_data;
	assign dm_rd_go = s_r.dm_rd_go;
	assign dm_wr_go = s_r.dm_wr_go;
	assign dm_region = s_r.dm_region;
	assign tag_wr_go = s_r.tag_wr_go;
	assign tag_wr_block = s_r.tag_wr_block;
	assign tag_wr_data = s_r.tag_wr_data;
	assign rf_state = s_r.st;

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence good_frame;
		frame_valid && frame_intact;
	endsequence
	sequence sel2_seen;
		good_frame and (s_r.st == NTSA_LVL2 && !frame_short && frame_data[31:0] == s_r.uid[55:24] &&
			frame_cmd == `NTSA_CMD_CL2 && frame_arg == `NTSA_ARG_SELECT);
	endsequence
	halt_holds_a: assert property ((s_r.st == NTSA_HALT && frame_valid && !is_wake) |=> s_r.st == NTSA_HALT)
		else $error("halt left without wake");
	idle_holds_a: assert property (
		(s_r.st == NTSA_IDLE && frame_valid && !is_req && !is_wake) |=> s_r.st == NTSA_IDLE)
		else $error("idle left without request");
	lock_monotone_a: assert property (
		(($past(s_r.rd_lock) & ~s_r.rd_lock) == 64'h0) && (($past(s_r.wr_lock) & ~s_r.wr_lock) == 64'h0))
		else $error("lock bit cleared");
	set_lock_gate_a: assert property (
		(s_r.st != NTSA_DM_AUTH) |=> s_r.rd_lock == $past(s_r.rd_lock) && s_r.wr_lock == $past(s_r.wr_lock))
		else $error("lock changed outside data auth");
	locked_fetch_a: assert property (
		(good_frame and ((s_r.st == NTSA_DM_ACT || s_r.st == NTSA_DM_AUTH) && !frame_short &&
		frame_cmd == `NTSA_CMD_DM_FETCH && frame_nbytes == `NTSA_NO_PAYLOAD && s_r.rd_lock[frame_arg[5:0]]))
		|=> rsp_kind == NTSA_RSP_NAK && !dm_rd_go)
		else $error("locked fetch not refused");
	// the answer is a pulse unless the reader sent another frame straight behind the select
	cascade_done_a: assert property (
		sel2_seen |=> (rf_state == NTSA_TAG_ACT && rsp_valid && rsp_kind == NTSA_RSP_SAK_DONE)
			##1 (!rsp_valid || $past(frame_valid)))
		else $error("level two select mishandled");
	read0_skip_a: assert property (
		(good_frame and ((s_r.st == NTSA_LVL1 || s_r.st == NTSA_LVL2) && is_read0))
		|=> rf_state == NTSA_TAG_ACT && rsp_kind == NTSA_RSP_DATA)
		else $error("read of block 0 did not skip");
	halt_wait_a: assert property (
		(good_frame and ((s_r.st == NTSA_TAG_ACT || s_r.st == NTSA_TAG_AUTH) && is_halt))
		|=> rf_state == NTSA_HALT && s_r.halted)
		else $error("halt request not taken");
	error_wait_a: assert property (
		(frame_valid && (s_r.st == NTSA_LVL1 || s_r.st == NTSA_LVL2) && !frame_intact)
		|=> rf_state == ($past(s_r.halted) ? NTSA_HALT : NTSA_IDLE))
		else $error("error did not return to wait state");
	guard_nak_a: assert property (
		(good_frame and (s_r.st == NTSA_TAG_ACT && is_read && guarded)) |=> rsp_kind == NTSA_RSP_NAK && rsp_data == 128'h0)
		else $error("guarded read not refused");
endmodule
`default_nettype wire

/* File: verif/ntsa_reader.sv */
/*
 * Proximity reader model: hands one decoded frame per call to the unit.
 * Assumes a running pclk and a unit that is out of reset.
 */
`default_nettype none
`include "ntsa_consts.svh"
module ntsa_reader (
	input wire logic pclk,
	output var logic frame_valid,
	output var logic frame_short,
	output var logic frame_intact,
	output var logic [7:0] frame_cmd,
	output var logic [7:0] frame_arg,
	output var logic [6:0] frame_nbytes,
	output var logic [63:0] frame_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// quiet lines at time zero
	initial begin
		{frame_valid, frame_short, frame_intact, frame_cmd, frame_arg, frame_nbytes, frame_data} = '0;
	end
	// frame stands one cycle; afterwards cmd, arg and data show the inverse so a stale frame never looks fresh
	task automatic send(input logic [7:0] c, input logic [7:0] a, input logic [6:0] n, input logic [63:0] d,
		input logic ok);
		@(posedge pclk);
		frame_valid <= 1'b1;
		frame_short <= (c == `NTSA_CMD_REQ || c == `NTSA_CMD_WAKE) && n == 7'h00;
		frame_intact <= ok;
		frame_cmd <= c;
		frame_arg <= a;
		frame_nbytes <= n;
		frame_data <= d;
		@(posedge pclk);
		frame_valid <= 1'b0;
		frame_cmd <= ~c;
		frame_arg <= ~a;
		frame_data <= ~d;
	endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
/*
 * Self-checking bench for the contactless state and access unit: APB master, reader, scenarios.
 * Assumes the package, the constants header and the unit are compiled first.
 */
`default_nettype none
`include "ntsa_consts.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ntsa_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, rsp_valid, dm_rd_go, dm_wr_go, tag_wr_go;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, tag_wr_data;
	logic [3:0] pstrb;
	logic [127:0] tag_rdata, rsp_data;
	logic [5:0] dm_region;
	logic [7:0] tag_wr_block;
	wire logic frame_valid, frame_short, frame_intact;
	wire logic [7:0] frame_cmd, frame_arg;
	wire logic [6:0] frame_nbytes;
	wire logic [63:0] frame_data;
	ntsa_rsp_t rsp_kind;
	ntsa_state_t rf_state;
	int n_errors, cmp_count;
	// tag memory stand-in: every byte shows the requested block number
	assign tag_rdata = {16{frame_arg}};
	ntsa_reader rdr_u (.pclk, .frame_valid, .frame_short, .frame_intact, .frame_cmd, .frame_arg,
		.frame_nbytes, .frame_data);
	ntsa_unit dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .frame_valid, .frame_short, .frame_intact, .frame_cmd, .frame_arg, .frame_nbytes,
		.frame_data, .tag_rdata, .rsp_valid, .rsp_kind, .rsp_data, .dm_rd_go, .dm_wr_go, .dm_region,
		.tag_wr_go, .tag_wr_block, .tag_wr_data, .rf_state);
	// 200 MHz clock
	always #2.5 pclk = ~pclk;
	task automatic conclude();
		if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// one APB transfer; answer taken at the edge that closes the access phase
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		// pready is looked at on rising edges only; read data is taken at the same edge
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		if (pready !== 1'b1) begin
			n_errors++;
			conclude();
		end
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	// one frame, then answer and state in the cycle after the edge that took it
	task automatic fx(input logic [7:0] c, input logic [7:0] a, input logic [6:0] n, input logic [63:0] d,
		input ntsa_rsp_t k, input ntsa_state_t s, input logic ok = 1'b1, input logic ck = 1'b1);
		rdr_u.send(c, a, n, d, ok);
		#1;
		if (ck) `CHK(rsp_valid, k != NTSA_RSP_NONE)
		if (ck && k != NTSA_RSP_NONE) `CHK(rsp_kind, k)
		`CHK(rf_state, s)
	endtask
	task automatic t_cascade();
		fx(8'h50, 8'h00, 0, 0, NTSA_RSP_NONE, NTSA_IDLE);
		fx(8'h26, 8'h00, 0, 0, NTSA_RSP_ATQ, NTSA_LVL1);
		fx(8'h93, 8'h20, 0, 0, NTSA_RSP_UID1, NTSA_LVL1);
		`CHK(rsp_data[23:0], 24'h332211)
		fx(8'h30, 8'h05, 0, 0, NTSA_RSP_NONE, NTSA_IDLE);
		fx(8'h26, 8'h00, 0, 0, NTSA_RSP_ATQ, NTSA_LVL1);
		fx(8'h93, 8'h70, 5, 24'h332211, NTSA_RSP_SAK_MORE, NTSA_LVL2);
		fx(8'h95, 8'h20, 0, 0, NTSA_RSP_UID2, NTSA_LVL2);
		`CHK(rsp_data[31:0], 32'h77665544)
		fx(8'h95, 8'h70, 5, 32'h77665544, NTSA_RSP_SAK_DONE, NTSA_TAG_ACT);
	endtask
	task automatic t_halt();
		fx(8'h50, 8'h00, 0, 0, NTSA_RSP_NONE, NTSA_HALT);
		fx(8'h26, 8'h00, 0, 0, NTSA_RSP_NONE, NTSA_HALT);
		fx(8'h52, 8'h00, 0, 0, NTSA_RSP_ATQ, NTSA_LVL1);
		fx(8'h30, 8'h00, 0, 0, NTSA_RSP_DATA, NTSA_TAG_ACT);
		fx(8'hc3, 8'h00, 0, 0, NTSA_RSP_NONE, NTSA_HALT);
		fx(8'h52, 8'h00, 0, 0, NTSA_RSP_ATQ, NTSA_LVL1);
		fx(8'h93, 8'h70, 5, 24'h332211, NTSA_RSP_SAK_MORE, NTSA_LVL2);
		fx(8'h95, 8'h20, 0, 0, NTSA_RSP_NONE, NTSA_HALT, 1'b0);
		fx(8'h52, 8'h00, 0, 0, NTSA_RSP_ATQ, NTSA_LVL1);
		fx(8'h93, 8'h70, 5, 24'h332211, NTSA_RSP_SAK_MORE, NTSA_LVL2);
		fx(8'h30, 8'h00, 0, 0, NTSA_RSP_DATA, NTSA_TAG_ACT);
	endtask
	task automatic t_guard();
		fx(8'h30, 8'h10, 0, 0, NTSA_RSP_NAK, NTSA_TAG_ACT);
		fx(8'ha2, 8'h10, 4, 32'hdeadbeef, NTSA_RSP_NAK, NTSA_TAG_ACT);
		`CHK(tag_wr_go, 1'b0)
		apb(1, `NTSA_OFS_KEY, 32'h0badf00d);
		fx(8'h1b, 8'h00, 4, 32'h12345678, NTSA_RSP_KEY_ACK, NTSA_TAG_AUTH);
		`CHK(rsp_data[15:0], 16'hbeef)
		fx(8'h30, 8'h10, 0, 0, NTSA_RSP_DATA, NTSA_TAG_AUTH);
		fx(8'ha2, 8'h10, 4, 32'hdeadbeef, NTSA_RSP_ACK, NTSA_TAG_AUTH);
		`CHK({tag_wr_go, tag_wr_block, tag_wr_data}, {1'b1, 8'h10, 32'hdeadbeef})
		apb(1, `NTSA_OFS_MIRROR, 32'h00000401);
		fx(8'h30, 8'h04, 0, 0, NTSA_RSP_DATA, NTSA_TAG_AUTH);
		`CHK(rsp_data[31:0], 32'h32323131)
		`CHK(rsp_data[127:96], 32'h04043737)
		apb(1, `NTSA_OFS_MIRROR, 32'h00000301);
		fx(8'h30, 8'h04, 0, 0, NTSA_RSP_DATA, NTSA_TAG_AUTH);
		`CHK(rsp_data, {16{8'h04}})
		fx(8'h50, 8'h00, 0, 0, NTSA_RSP_NONE, NTSA_HALT);
	endtask
	task automatic t_dm();
		fx(8'h52, 8'h00, 0, 0, NTSA_RSP_ATQ, NTSA_LVL1);
		fx(8'h30, 8'h00, 0, 0, NTSA_RSP_DATA, NTSA_TAG_ACT);
		fx(8'h51, 8'h00, 0, 0, NTSA_RSP_NONE, NTSA_DM_ACT);
		fx(8'h6a, 8'h00, 0, 0, NTSA_RSP_LOCKMAP, NTSA_DM_ACT);
		fx(8'h40, 8'h00, 4, 32'hcafe0001, NTSA_RSP_ACK, NTSA_DM_AUTH);
		fx(8'h7f, 8'h00, 8, 64'hf0, NTSA_RSP_ACK, NTSA_DM_AUTH);
		fx(8'h7f, 8'h00, 8, 64'h05, NTSA_RSP_ACK, NTSA_DM_AUTH);
		fx(8'h6a, 8'h00, 0, 0, NTSA_RSP_LOCKMAP, NTSA_DM_AUTH);
		`CHK(rsp_data[63:0], 64'hf5)
		fx(8'h51, 8'h00, 0, 0, NTSA_RSP_NAK, NTSA_DM_AUTH);
		fx(8'h51, 8'h01, 0, 0, NTSA_RSP_DM_DATA, NTSA_DM_AUTH);
		`CHK({dm_rd_go, dm_region}, 7'h41)
		fx(8'h54, 8'h03, 7'h40, 0, NTSA_RSP_ACK, NTSA_DM_AUTH);
		`CHK({dm_wr_go, dm_region}, 7'h43)
		fx(8'h7e, 8'h00, 8, 64'h08, NTSA_RSP_ACK, NTSA_DM_AUTH);
		fx(8'h54, 8'h03, 7'h40, 0, NTSA_RSP_NAK, NTSA_DM_AUTH);
		`CHK(dm_wr_go, 1'b0)
		fx(8'hc3, 8'h00, 0, 0, NTSA_RSP_NONE, NTSA_IDLE);
	endtask
	task automatic t_unauth();
		fx(8'h52, 8'h00, 0, 0, NTSA_RSP_ATQ, NTSA_LVL1);
		fx(8'h30, 8'h00, 0, 0, NTSA_RSP_DATA, NTSA_TAG_ACT);
		fx(8'h51, 8'h00, 0, 0, NTSA_RSP_NONE, NTSA_DM_ACT);
		fx(8'h6c, 8'h00, 0, 0, NTSA_RSP_LOCKMAP, NTSA_DM_ACT);
		rdr_u.send(8'h7e, 8'h00, 8, 64'hff, 1'b1);
		apb(0, `NTSA_OFS_WRLK_LO, 0);
		`CHK(rd, 32'h8)
		fx(8'hc3, 8'h00, 0, 0, NTSA_RSP_NONE, NTSA_IDLE);
	endtask
	// reset, configuration, then the scenarios in order
	initial begin
		{pclk, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		n_errors = 0;
		cmp_count = 0;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		`CHK(rf_state, NTSA_IDLE)
		apb(0, `NTSA_OFS_GUARD, 0);
		`CHK(rd[7:0], `NTSA_GUARD_OFF)
		apb(0, 12'h100, 0);
		`CHK(er, 1'b1)
		apb(1, `NTSA_OFS_UID_LO, 32'h44332211);
		apb(1, `NTSA_OFS_UID_HI, 32'h00776655);
		apb(1, `NTSA_OFS_KEY, 32'h12345678);
		apb(1, `NTSA_OFS_KEY_ACK, 32'h0000beef);
		apb(1, `NTSA_OFS_DM_KEY, 32'hcafe0001);
		apb(1, `NTSA_OFS_GUARD, 32'h00000010);
		t_cascade();
		t_halt();
		t_guard();
		t_dm();
		t_unauth();
		conclude();
	end
endmodule
`default_nettype wire
